// >>> rtl/mbtcp_regs.svh
// Frame positions, function codes and limits of the request decoder
`ifndef MBTCP_REGS_SVH
`define MBTCP_REGS_SVH
// Byte positions within a received frame
`define POS_TID_HI   17'd0
`define POS_TID_LO   17'd1
`define POS_PID_HI   17'd2
`define POS_PID_LO   17'd3
`define POS_LEN_HI   17'd4
`define POS_LEN_LO   17'd5
`define POS_UNIT     17'd6
`define POS_FUNC     17'd7
`define POS_ADDR_HI  17'd8
`define POS_ADDR_LO  17'd9
`define POS_QTY_HI   17'd10
`define POS_QTY_LO   17'd11
`define POS_BCNT     17'd12
`define POS_VAL_FST  17'd13
// Position of the last header byte before the length count
`define LEN_BIAS     17'd5
// Supported function codes
`define FC_RD_RELAY  8'h01
`define FC_RD_DIN    8'h02
`define FC_RD_REGS   8'h03
`define FC_WR_RELAY  8'h05
`define FC_WR_REGS   8'h10
// Relay control values
`define RELAY_ON     16'hff00
`define RELAY_OFF    16'h0000
// Limits
`define UNIT_MAX     8'hf7
`define RELAY_COUNT  8
`define DIN_COUNT    28
// Reply positions and fixed reply length
`define TX_DATA_FST  17'd9
`define TX_ECHO_LEN  16'h0006
`endif

// >>> rtl/mbtcp_pkg.sv
// Types shared by the request decoder modules
package mbtcp_pkg;
   // Fields captured from one request frame
   typedef struct packed {
      logic [15:0] tid;
      logic [15:0] pid;
      logic [15:0] len;
      logic [7:0]  unit;
      logic [7:0]  func;
      logic [15:0] addr;
      logic [15:0] qty;
      logic [7:0]  bcnt;
   } req_hdr_s;
   // Decoder phases
   typedef enum logic {ST_RECV, ST_REPLY} dec_state_e;
endpackage : mbtcp_pkg

// >>> rtl/frame_parse.sv
// Request byte counter and header field capture
`timescale 1ns/10ps
`include "mbtcp_regs.svh"
module frame_parse
   import mbtcp_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_rx_valid,
   input  wire logic [7:0]  i_rx_data,
   input  wire logic        i_hold,
   output logic             o_rx_ready,
   output logic             o_take,
   output req_hdr_s         o_hdr,
   output logic [16:0]      o_pos,
   output logic             o_done
);
   logic        last;     // Byte now taken closes the frame
   logic [16:0] end_pos;  // Position of the closing byte

   // Back-pressure while a reply is out
   assign o_rx_ready = !i_hold;
   assign o_take     = i_rx_valid && o_rx_ready;
   // [RQ3] Length finds end
   assign end_pos = {1'b0, o_hdr.len} + `LEN_BIAS;
   // A length below one still ends after the unit byte
   assign last = (o_pos >= `POS_UNIT) && (o_pos >= end_pos);

   // Position counter restarts after each frame
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pos <= 17'd0;
      end else if (o_take) begin
         o_pos <= last ? 17'd0 : o_pos + 17'd1;
      end
   end

   // Frame-complete pulse, fields are settled by then
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_done <= 1'b0;
      end else begin
         o_done <= o_take && last;
      end
   end

   // [RQ1] Header field capture
   // [RQ13] High byte first
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_hdr <= '0;
      end else if (o_take) begin
         case (o_pos)
            `POS_TID_HI:  o_hdr.tid[15:8]  <= i_rx_data;
            `POS_TID_LO:  o_hdr.tid[7:0]   <= i_rx_data;
            `POS_PID_HI:  o_hdr.pid[15:8]  <= i_rx_data;
            `POS_PID_LO:  o_hdr.pid[7:0]   <= i_rx_data;
            `POS_LEN_HI:  o_hdr.len[15:8]  <= i_rx_data;
            `POS_LEN_LO:  o_hdr.len[7:0]   <= i_rx_data;
            `POS_UNIT:    o_hdr.unit       <= i_rx_data;
            `POS_FUNC:    o_hdr.func       <= i_rx_data;
            `POS_ADDR_HI: o_hdr.addr[15:8] <= i_rx_data;
            `POS_ADDR_LO: o_hdr.addr[7:0]  <= i_rx_data;
            `POS_QTY_HI:  o_hdr.qty[15:8]  <= i_rx_data;
            `POS_QTY_LO:  o_hdr.qty[7:0]   <= i_rx_data;
            `POS_BCNT:    o_hdr.bcnt       <= i_rx_data;
            default:      o_hdr            <= o_hdr;
         endcase
      end
   end
endmodule : frame_parse

// >>> rtl/mbtcp_decoder.sv
// Modbus-TCP request decoder with reply former
// Behaviour
// [RQ1] Seven-byte header, function, then data
// [RQ2] Transaction id kept and echoed
// [RQ3] Length field marks end, set in replies
// [RQ4] Unit id valid from 0 to 247
// [RQ5] Function code selects the action
// [RQ6] Code 01 returns relay states
// [RQ7] Code 02 returns digital input states
// [RQ8] Code 03 returns register contents
// [RQ9] Code 05 drives one relay
// [RQ10] Code 16 writes consecutive registers
// [RQ11] Read request carries start and count
// [RQ12] Write carries start, count, bytes, data
// [RQ13] Two-byte fields sent high byte first
// [RQ14] Eight relays from address zero, 1=on
// [RQ15] One reply per request
// [RQ16] Only FF00 or 0000 change relay
// [RQ17] Relay control reply echoes request
// [RQ18] Bad protocol or code is dropped
`timescale 1ns/10ps
`include "mbtcp_regs.svh"
module mbtcp_decoder
   import mbtcp_pkg::*;
(
   input  wire logic                    i_sys_clk,
   input  wire logic                    i_rstn,
   input  wire logic                    i_rx_valid,
   input  wire logic [7:0]              i_rx_data,
   output logic                         o_rx_ready,
   output logic                         o_tx_valid,
   output logic [7:0]                   o_tx_data,
   output logic                         o_tx_last,
   input  wire logic                    i_tx_ready,
   input  wire logic [`DIN_COUNT-1:0]   i_digital_input,
   output logic [`RELAY_COUNT-1:0]      o_relay,
   output logic [15:0]                  o_reg_rd_addr,
   input  wire logic [15:0]             i_reg_rd_data,
   output logic                         o_reg_wr_en,
   output logic [15:0]                  o_reg_wr_addr,
   output logic [15:0]                  o_reg_wr_data
);
   req_hdr_s    hdr;        // Captured request fields
   logic [16:0] pos;        // Position of the byte on the rx port
   logic        take;       // Rx byte accepted
   logic        done;       // Request complete pulse
   dec_state_e  state;      // Receive or reply phase
   logic        accept;     // Request passes the checks
   logic [15:0] rep_len;    // Length field of the reply
   logic [15:0] next_len;   // Reply length worked out at done
   logic [16:0] idx;        // Next reply byte to load
   logic [16:0] total;      // Reply bytes in all
   logic [7:0]  next_byte;  // Reply byte at idx
   logic [16:0] dofs;       // Offset into the reply data
   logic [16:0] rdofs;      // Register offset for code 03
   logic [7:0]  wr_hi;      // High half of a pending write
   logic [16:0] wofs;       // Register offset for code 16
   logic        tx_go;      // Output slot free
   logic        fc_ok;      // Function code supported
   logic        hold;       // Rx port stalled

   // Extract eight status bits from a vector at a bit start
   // Bits past the vector read as zero; bits past the count are not masked
   function automatic logic [7:0] bit_byte(input logic [31:0] v,
                                           input logic [16:0] s);
      logic [7:0] b;
      b = 8'h00;
      for (int j = 0; j < 8; j++) begin
         if (s + 17'(j) < 17'd32) begin
            b[j] = v[5'(s + 17'(j))];
         end
      end
      return b;
   endfunction : bit_byte

   // [RQ2] Keep reply fields
   // The rx port also stalls in the done cycle: a byte of the next frame
   // taken there would overwrite the transaction id before it is echoed.
   // The cost is one idle cycle after every frame, dropped ones included.
   assign hold = (state != ST_RECV) || done;

   // Byte counter and header capture
   frame_parse u_parse (
      .i_sys_clk  (i_sys_clk),
      .i_rstn     (i_rstn),
      .i_rx_valid (i_rx_valid),
      .i_rx_data  (i_rx_data),
      .i_hold     (hold),
      .o_rx_ready (o_rx_ready),
      .o_take     (take),
      .o_hdr      (hdr),
      .o_pos      (pos),
      .o_done     (done)
   );

   // [RQ5] Code selects action
   assign fc_ok = (hdr.func == `FC_RD_RELAY) ||
                  (hdr.func == `FC_RD_DIN)   ||
                  (hdr.func == `FC_RD_REGS)  ||
                  (hdr.func == `FC_WR_RELAY) ||
                  (hdr.func == `FC_WR_REGS);
   // [RQ18] Drop bad frames
   // [RQ4] Unit range check
   assign accept = (hdr.pid == 16'h0000) && fc_ok &&
                   (hdr.unit <= `UNIT_MAX);

   // Reply length per code; bits pack eight to a byte
   always_comb begin
      next_len = `TX_ECHO_LEN;
      case (hdr.func)
         `FC_RD_RELAY, `FC_RD_DIN:
            next_len = 16'd3 + {3'd0, 13'((hdr.qty + 16'd7) >> 3)};
         `FC_RD_REGS:
            next_len = 16'd3 + {hdr.qty[14:0], 1'b0};
         default:
            next_len = `TX_ECHO_LEN;
      endcase
   end

   // [RQ15] One reply per request
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state   <= ST_RECV;
         rep_len <= 16'h0000;
      end else begin
         case (state)
            ST_RECV: begin
               if (done && accept) begin
                  state   <= ST_REPLY;
                  rep_len <= next_len;
               end
            end
            ST_REPLY: begin
               if (o_tx_valid && o_tx_last && i_tx_ready) begin
                  state <= ST_RECV;
               end
            end
            default: state <= ST_RECV;
         endcase
      end
   end

   // [RQ9] Single relay drive
   // [RQ14] Eight relays, bit per relay
   // [RQ16] Only two legal values
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_relay <= '0;
      end else if (state == ST_RECV && done && accept &&
                   hdr.func == `FC_WR_RELAY &&
                   hdr.addr < 16'(`RELAY_COUNT)) begin
         if (hdr.qty == `RELAY_ON) begin
            o_relay[hdr.addr[2:0]] <= 1'b1;
         end else if (hdr.qty == `RELAY_OFF) begin
            o_relay[hdr.addr[2:0]] <= 1'b0;
         end
      end
   end

   // [RQ10] Stream register writes
   // [RQ12] Start, count, bytes, data
   // Writes land as pairs arrive, so a frame cut short keeps them
   assign wofs = (pos - `POS_VAL_FST) >> 1;
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_hi         <= 8'h00;
         o_reg_wr_en   <= 1'b0;
         o_reg_wr_addr <= 16'h0000;
         o_reg_wr_data <= 16'h0000;
      end else begin
         o_reg_wr_en <= 1'b0;
         if (take && hdr.func == `FC_WR_REGS && hdr.pid == 16'h0000 &&
             hdr.unit <= `UNIT_MAX && pos >= `POS_VAL_FST &&
             wofs < {1'b0, hdr.qty}) begin
            if (pos[0]) begin
               wr_hi <= i_rx_data;
            end else begin
               o_reg_wr_en   <= 1'b1;
               o_reg_wr_addr <= hdr.addr + wofs[15:0];
               o_reg_wr_data <= {wr_hi, i_rx_data};
            end
         end
      end
   end

   // Reply data offsets
   // Index 8 carries the byte count, so data starts at index 9
   assign dofs  = idx - `TX_DATA_FST;
   assign rdofs = dofs >> 1;
   // Read data must follow the address in the same cycle, no wait state
   // [RQ8] Register read port
   // [RQ11] Start then count
   assign o_reg_rd_addr = hdr.addr + rdofs[15:0];
   assign total = {1'b0, rep_len} + 17'd6;

   // [RQ2] Echo transaction id
   // [RQ3] Reply length field
   // [RQ17] Code 05 echo
   always_comb begin
      next_byte = 8'h00;
      case (idx)
         `POS_TID_HI: next_byte = hdr.tid[15:8];
         `POS_TID_LO: next_byte = hdr.tid[7:0];
         `POS_PID_HI: next_byte = 8'h00;
         `POS_PID_LO: next_byte = 8'h00;
         `POS_LEN_HI: next_byte = rep_len[15:8];
         `POS_LEN_LO: next_byte = rep_len[7:0];
         `POS_UNIT:   next_byte = hdr.unit;
         `POS_FUNC:   next_byte = hdr.func;
         default: begin
            if (hdr.func == `FC_WR_RELAY || hdr.func == `FC_WR_REGS) begin
               case (idx)
                  `POS_ADDR_HI: next_byte = hdr.addr[15:8];
                  `POS_ADDR_LO: next_byte = hdr.addr[7:0];
                  `POS_QTY_HI:  next_byte = hdr.qty[15:8];
                  default:      next_byte = hdr.qty[7:0];
               endcase
            end else if (idx == `POS_ADDR_HI) begin
               // Byte count of the data part
               next_byte = 8'(rep_len - 16'd3);
            end else if (hdr.func == `FC_RD_REGS) begin
               next_byte = dofs[0] ? i_reg_rd_data[7:0]
                                   : i_reg_rd_data[15:8];
            end else if (hdr.func == `FC_RD_RELAY) begin
               // [RQ6] Relay status bits
               next_byte = bit_byte({24'h0, o_relay},
                                    {1'b0, hdr.addr} + (dofs << 3));
            end else begin
               // [RQ7] Digital input bits
               next_byte = bit_byte({4'h0, i_digital_input},
                                    {1'b0, hdr.addr} + (dofs << 3));
            end
         end
      endcase
   end

   // Output register loads the next reply byte whenever the slot is free and reply bytes remain
   // A byte waits in the register until the sink takes it
   assign tx_go = !o_tx_valid || i_tx_ready;
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         idx        <= 17'd0;
         o_tx_valid <= 1'b0;
         o_tx_data  <= 8'h00;
         o_tx_last  <= 1'b0;
      end else if (state == ST_REPLY && tx_go && idx < total) begin
         // [RQ13] High byte first
         o_tx_valid <= 1'b1;
         o_tx_data  <= next_byte;
         o_tx_last  <= (idx + 17'd1 == total);
         idx        <= idx + 17'd1;
      end else if (tx_go) begin
         o_tx_valid <= 1'b0;
         o_tx_last  <= 1'b0;
         if (state != ST_REPLY) begin
            idx <= 17'd0;
         end
      end
   end

   // A rejected frame never opens a reply
   a_drop_frame: assert property ( // [RQ18]
      @(posedge i_sys_clk) disable iff (!i_rstn)
      done && !accept |=> state == ST_RECV && !o_tx_valid)
      else $error("Rejected frame started a reply");

   // A legal on value sets the addressed relay
   a_relay_on: assert property ( // [RQ9]
      @(posedge i_sys_clk) disable iff (!i_rstn)
      state == ST_RECV && done && accept && hdr.func == 8'h05 &&
      hdr.addr < 16'd8 && hdr.qty == 16'hff00
      |=> o_relay[$past(hdr.addr[2:0])])
      else $error("Relay not switched on");

   // Any other value leaves every relay alone
   a_relay_bad: assert property ( // [RQ16]
      @(posedge i_sys_clk) disable iff (!i_rstn)
      done && hdr.qty != 16'hff00 && hdr.qty != 16'h0000
      |=> $stable(o_relay))
      else $error("Illegal value changed a relay");

   // Replies open with the high byte of the kept id
   a_tid_first: assert property ( // [RQ2]
      @(posedge i_sys_clk) disable iff (!i_rstn)
      $rose(o_tx_valid) && state == ST_REPLY
      |-> o_tx_data == hdr.tid[15:8] && !o_tx_last)
      else $error("Reply does not open with transaction id");

   // Relay control and write replies carry a length field of six
   a_echo_len: assert property ( // [RQ17]
      @(posedge i_sys_clk) disable iff (!i_rstn)
      done && accept && (hdr.func == 8'h05 || hdr.func == 8'h10)
      |=> rep_len == 16'h0006)
      else $error("Echo reply length wrong");

   // Register read replies (code 03) count two bytes per register
   a_read_len: assert property ( // [RQ3]
      @(posedge i_sys_clk) disable iff (!i_rstn)
      state == ST_RECV && done && accept && hdr.func == 8'h03
      |=> rep_len == 16'd3 + {$past(hdr.qty[14:0]), 1'b0})
      else $error("Register read reply length wrong");

   // Only code 16 frames reach the write port
   a_wr_only16: assert property ( // [RQ10]
      @(posedge i_sys_clk) disable iff (!i_rstn)
      o_reg_wr_en |-> hdr.func == 8'h10 && hdr.pid == 16'h0000)
      else $error("Register write outside code 16");

   // Request fields hold still while the reply goes out
   a_rx_stalled: assert property ( // [RQ15]
      @(posedge i_sys_clk) disable iff (!i_rstn)
      state == ST_REPLY |-> !o_rx_ready && $stable(hdr))
      else $error("Request taken while replying");

   // The reply ends at its last byte
   a_one_reply: assert property ( // [RQ15]
      @(posedge i_sys_clk) disable iff (!i_rstn)
      o_tx_valid && o_tx_last && i_tx_ready
      |=> state == ST_RECV ##1 !o_tx_valid)
      else $error("Reply ran past its last byte");
endmodule : mbtcp_decoder

// >>> dv/mb_master.sv
// Behavioural network master that feeds request bytes and sinks replies
`timescale 1ns/10ps
module mb_master (
   input  wire logic       i_sys_clk,
   input  wire logic       i_slow,
   input  wire logic       i_rx_ready,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   input  wire logic       i_tx_last,
   output logic            o_rx_valid,
   output logic [7:0]      o_rx_data,
   output logic            o_tx_ready
);
   logic [7:0] req_q[$];   // Bytes still to send, wire order
   logic [7:0] rsp_q[$];   // Reply bytes collected
   int         num_last;   // Replies seen complete
   int         tick;       // Cycle count for the slow sink
   logic       was_taken;  // Request byte accepted at this edge
   logic [7:0] last_byte;  // Last byte sent, to scramble idle data

   // Drive after each edge; hold a byte until the decoder takes it
   initial begin
      o_rx_valid = 1'b0;
      o_rx_data  = 8'hff;
      o_tx_ready = 1'b0;
      num_last   = 0;
      tick       = 0;
      last_byte  = 8'h00;
      forever begin
         @(posedge i_sys_clk);
         was_taken = o_rx_valid && i_rx_ready;
         if (i_tx_valid && o_tx_ready) begin
            rsp_q.push_back(i_tx_data);
            if (i_tx_last) num_last++;
         end
         #1;
         if (was_taken) last_byte = req_q.pop_front();
         tick++;
         // Slow mode stalls the reply two cycles in three
         o_tx_ready = !i_slow || (tick % 3 == 0);
         if (req_q.size() > 0) begin
            o_rx_valid = 1'b1;
            o_rx_data  = req_q[0];
         end else begin
            // Idle line shows no stale byte
            o_rx_valid = 1'b0;
            o_rx_data  = ~last_byte;
         end
      end
   end
endmodule : mb_master

// >>> dv/mbtcp_decoder_tb.sv
// Self-checking bench for the request decoder
`timescale 1ns/10ps
module mbtcp_decoder_tb;
   import mbtcp_pkg::*;
   // One request case: frame, expected replies and relay state
   typedef struct {
      logic [191:0] req;
      int           rn;
      logic [175:0] rsp;
      int           sn;
      int           nl;
      logic [7:0]   relay;
   } row_s;

   logic        i_sys_clk;        // System clock
   logic        i_rstn;           // Active-low reset
   logic        rx_valid;         // Request byte valid
   logic [7:0]  rx_data;          // Request byte
   logic        o_rx_ready;       // Decoder takes request byte
   logic        o_tx_valid;       // Reply byte valid
   logic [7:0]  o_tx_data;        // Reply byte
   logic        o_tx_last;        // Last reply byte
   logic        tx_ready;         // Sink ready
   logic        slow;             // Sink stalls when set
   logic [27:0] din;              // Digital input levels
   logic [7:0]  o_relay;          // Relay states
   logic [15:0] o_reg_rd_addr;    // Register read address
   logic [15:0] rd_data;          // Register read data
   logic        o_reg_wr_en;      // Register write pulse
   logic [15:0] o_reg_wr_addr;    // Register write address
   logic [15:0] o_reg_wr_data;    // Register write data
   logic [31:0] wr_q[$];          // Writes seen, address then data
   int          num_errors;       // Mismatches
   int          num_checks;       // Comparisons
   int          cyc;              // Cycle counter for the timeout
   row_s        rows[10];         // Ordinary cases
   row_s        b2b;              // Back-to-back case

   // Registers read as a pattern of their own address
   assign rd_data = {o_reg_rd_addr[7:0], ~o_reg_rd_addr[7:0]};

   mbtcp_decoder dut (
      .i_sys_clk       (i_sys_clk),
      .i_rstn          (i_rstn),
      .i_rx_valid      (rx_valid),
      .i_rx_data       (rx_data),
      .o_rx_ready      (o_rx_ready),
      .o_tx_valid      (o_tx_valid),
      .o_tx_data       (o_tx_data),
      .o_tx_last       (o_tx_last),
      .i_tx_ready      (tx_ready),
      .i_digital_input (din),
      .o_relay         (o_relay),
      .o_reg_rd_addr   (o_reg_rd_addr),
      .i_reg_rd_data   (rd_data),
      .o_reg_wr_en     (o_reg_wr_en),
      .o_reg_wr_addr   (o_reg_wr_addr),
      .o_reg_wr_data   (o_reg_wr_data)
   );

   mb_master u_m (
      .i_sys_clk  (i_sys_clk),
      .i_slow     (slow),
      .i_rx_ready (o_rx_ready),
      .i_tx_valid (o_tx_valid),
      .i_tx_data  (o_tx_data),
      .i_tx_last  (o_tx_last),
      .o_rx_valid (rx_valid),
      .o_rx_data  (rx_data),
      .o_tx_ready (tx_ready)
   );

   // Clock at 100 MHz
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   // Record every register write pulse
   always @(posedge i_sys_clk) begin
      if (o_reg_wr_en === 1'b1) begin
         wr_q.push_back({o_reg_wr_addr, o_reg_wr_data});
      end
   end

   // A hang counts as a mismatch
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         close_out();
      end
   end

   // One comparison, reported at once on mismatch
   task automatic check(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : check

   // Send a frame set, wait for its replies, compare them
   task automatic run_row(input row_s r);
      int n;
      int tgt;
      tgt = u_m.num_last + r.nl;
      for (int i = 0; i < r.rn; i++) begin
         u_m.req_q.push_back(r.req[8*(r.rn-1-i) +: 8]);
      end
      n = 0;
      while (n < 400 && (u_m.req_q.size() > 0 || u_m.num_last < tgt)) begin
         @(posedge i_sys_clk);
         n++;
      end
      // Dropped frames get time in which a reply would have come
      repeat (10) @(posedge i_sys_clk);
      #1;
      check("reply count", r.sn, u_m.rsp_q.size());
      // A missing last flag leaves the reply unclosed
      check("reply ends", tgt, u_m.num_last);
      for (int i = 0; i < r.sn; i++) begin
         check("reply byte", r.rsp[8*(r.sn-1-i) +: 8], u_m.rsp_q[i]);
      end
      check("relay", r.relay, o_relay);
      u_m.rsp_q.delete();
   endtask : run_row

   // Counts, verdict and end of run
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   // Main sequence
   initial begin
      i_rstn = 1'b0;
      slow = 1'b0;
      din = 28'h000000a;
      num_errors = 0;
      num_checks = 0;
      cyc = 0;
      // Requests as the master sends them
      rows[0] = '{192'h0001_0000_0006_0105_0002_ff00, 12,
                  176'h0001_0000_0006_0105_0002_ff00, 12, 1, 8'h04};
      rows[1] = '{192'h0002_0000_0006_0101_0000_0008, 12,
                  176'h0002_0000_0004_0101_0104, 10, 1, 8'h04};
      rows[2] = '{192'h0003_0000_0006_0102_0000_0004, 12,
                  176'h0003_0000_0004_0102_010a, 10, 1, 8'h04};
      rows[3] = '{192'h0004_0000_0006_0103_1040_0002, 12,
                  176'h0004_0000_0007_0103_0440_bf41_be, 13, 1, 8'h04};
      rows[4] = '{192'h0005_0000_000b_0110_1008_0002_0401_f400_05, 17,
                  176'h0005_0000_0006_0110_1008_0002, 12, 1, 8'h04};
      rows[5] = '{192'h0006_0000_0006_0105_0003_1234, 12,
                  176'h0006_0000_0006_0105_0003_1234, 12, 1, 8'h04};
      rows[6] = '{192'h0007_0001_0006_0105_0000_ff00, 12, 176'h0, 0, 0, 8'h04};
      rows[7] = '{192'h0008_0000_0006_f805_0000_ff00, 12, 176'h0, 0, 0, 8'h04};
      rows[8] = '{192'h0009_0000_0006_0104_0000_0001, 12, 176'h0, 0, 0, 8'h04};
      rows[9] = '{192'h000a_0000_0006_f705_0002_0000, 12,
                  176'h000a_0000_0006_f705_0002_0000, 12, 1, 8'h00};
      // Ids differ in the high byte, so a clobbered id shows
      b2b = '{{96'h000b_0000_0006_0105_0005_ff00,
               96'h010c_0000_0006_0101_0000_0008}, 24,
              {96'h000b_0000_0006_0105_0005_ff00,
               80'h010c_0000_0004_0101_0120}, 22, 2, 8'h20};
      repeat (8) @(posedge i_sys_clk);
      #1;
      check("ready in reset", 1, o_rx_ready);
      check("valid in reset", 0, o_tx_valid);
      check("relay in reset", 0, o_relay);
      repeat (8) @(posedge i_sys_clk);
      #1;
      i_rstn = 1'b1;
      for (int k = 0; k < 10; k++) begin
         run_row(rows[k]);
      end
      check("write count", 2, wr_q.size());
      check("write first", 32'h1008_01f4, wr_q[0]);
      check("write second", 32'h1009_0005, wr_q[1]);
      // Back to back, distinct ids, stalling sink
      slow = 1'b1;
      run_row(b2b);
      slow = 1'b0;
      // Reset in mid-run clears the relays
      @(posedge i_sys_clk);
      #1;
      i_rstn = 1'b0;
      @(posedge i_sys_clk);
      #1;
      check("relay after reset", 0, o_relay);
      check("ready after reset", 1, o_rx_ready);
      i_rstn = 1'b1;
      run_row(rows[0]);
      close_out();
   end
endmodule : mbtcp_decoder_tb
